// ===== shared/fps_pkg.sv
`default_nettype none
package fps_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_BLANK_NS    = 2000;
  localparam int BLANK_CYC     = (T_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_MAX_ON_NS   = 25000;
  localparam int MAX_ON_CYC    = T_MAX_ON_NS / CLK_PERIOD_NS;
  localparam int FMAX_KHZ      = 125;
  localparam int T_MIN_PER_NS  = 1000000 / FMAX_KHZ;
  localparam int MIN_PER_CYC   =
    (T_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VCO_STEP_CYC  = 200;
  localparam int RESTART_CYC   = 4000;

  // Register map
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  STAT_OFS    = 4'h4;
  localparam int          CTRL_FB_EN  = 0;
  localparam int          CTRL_PFC_EN = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Comparator vector positions
  localparam int N_IN         = 16;
  localparam int IN_OVP       = 0;
  localparam int IN_OLOOP_OK  = 1;
  localparam int IN_BURST_LO  = 2;
  localparam int IN_BURST_HI  = 3;
  localparam int IN_FB_START  = 4;
  localparam int IN_VCC_START = 5;
  localparam int IN_SS_DONE   = 6;
  localparam int IN_PEAK      = 7;
  localparam int IN_CTRL_BIAS = 8;
  localparam int IN_CTRL_TOUT = 9;
  localparam int IN_CTRL_GND  = 10;
  localparam int IN_VCO       = 11;
  localparam int IN_DEMAG     = 12;
  localparam int IN_DEMAG_OPN = 13;
  localparam int IN_VALLEY    = 14;
  localparam int IN_PFC_REQ   = 15;

  typedef enum logic [2:0] {
    FB_IDLE    = 3'h0,
    FB_ON      = 3'h1,
    FB_SEC     = 3'h3,
    FB_WAIT    = 3'h2,
    FB_RESTART = 3'h6
  } fps_fb_state_t;
endpackage
`default_nettype wire

// ===== logic/fps_sequencer.sv
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer #(
  parameter int MAX_ON_CYC = fps_pkg::MAX_ON_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [fps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [fps_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      bus_overvoltage_cmp,
  input  wire logic                      open_loop_ok_cmp,
  input  wire logic                      burst_low_cmp,
  input  wire logic                      burst_high_cmp,
  input  wire logic                      flyback_start_level_cmp,
  input  wire logic                      supply_start_cmp,
  input  wire logic                      softstart_done_cmp,
  input  wire logic                      flyback_peak_cmp,
  input  wire logic                      control_bias_cmp,
  input  wire logic                      control_timeout_cmp,
  input  wire logic                      control_ground_cmp,
  input  wire logic                      low_power_frequency_mode_cmp,
  input  wire logic                      flyback_demag_input,
  input  wire logic                      demag_open_cmp,
  input  wire logic                      high_voltage_valley_input,
  input  wire logic                      correction_stage_request,
  input  wire logic [7:0]                flyback_control_level,
  output logic                           correction_stage_gate_output,
  output logic                           compensation_clamp_request,
  output logic                           correction_softstart_request,
  output logic                           correction_burst_mode,
  output logic                           flyback_gate_output,
  output logic                           peak_limit_quarter,
  output logic                           control_bias_enable,
  output logic                           flyback_softstart_current,
  output logic                           open_loop_fault,
  output logic                           safe_restart
);

  typedef struct packed {
    logic [fps_pkg::N_IN-1:0]   sync1;
    logic [fps_pkg::N_IN-1:0]   sync2;
    logic [1:0]                 ctrl;
    logic                       awready;
    logic                       aw_full;
    logic [fps_pkg::ADDR_W-1:0] awaddr;
    logic                       wready;
    logic                       w_full;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    fps_pkg::fps_fb_state_t     fb_state;
    logic [12:0]                on_cnt;
    logic [8:0]                 blank_cnt;
    logic [15:0]                osc_cnt;
    logic [11:0]                restart_cnt;
    logic                       started;
    logic                       fb_gate;
    logic                       pfc_gate;
    logic                       clamp;
    logic                       burst;
    logic                       burst_hold;
    logic                       pfc_ss;
    logic                       quarter;
    logic                       bias_en;
    logic                       ss_en;
    logic                       tout_fault;
    logic                       restart;
  } fps_state_t;

  fps_state_t s_r;
  fps_state_t s_nxt;

  // Register select: 0 control, 1 status, 2 unmapped
  function automatic logic [1:0] reg_sel(
    input logic [fps_pkg::ADDR_W-1:0] addr
  );
    if (addr == fps_pkg::CTRL_OFS) begin
      return 2'h0;
    end else if (addr == fps_pkg::STAT_OFS) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction

  logic [fps_pkg::N_IN-1:0] pins;
  logic                     ovp;
  logic                     loop_ok;
  logic                     demag;
  logic                     fb_fault;
  logic                     osc_high;
  logic                     valley_ready;
  logic [16:0]              vco_per;
  logic [31:0]              status;

  assign pins = {correction_stage_request, high_voltage_valley_input,
                 demag_open_cmp, flyback_demag_input,
                 low_power_frequency_mode_cmp, control_ground_cmp,
                 control_timeout_cmp, control_bias_cmp, flyback_peak_cmp,
                 softstart_done_cmp, supply_start_cmp,
                 flyback_start_level_cmp, burst_high_cmp, burst_low_cmp,
                 open_loop_ok_cmp, bus_overvoltage_cmp};

  // Decisions read only the second synchroniser stage
  assign ovp      = s_r.sync2[fps_pkg::IN_OVP];
  assign loop_ok  = s_r.sync2[fps_pkg::IN_OLOOP_OK];
  assign demag    = s_r.sync2[fps_pkg::IN_DEMAG];
  assign fb_fault = s_r.sync2[fps_pkg::IN_CTRL_TOUT]
                  | s_r.sync2[fps_pkg::IN_CTRL_GND]
                  | s_r.sync2[fps_pkg::IN_DEMAG_OPN]
                  | !s_r.ctrl[fps_pkg::CTRL_FB_EN];
  // Low-power mode stretches the period as the control level falls
  assign vco_per  = 17'(fps_pkg::MIN_PER_CYC)
                  + 17'((8'hff - flyback_control_level)
                        * fps_pkg::VCO_STEP_CYC);
  assign osc_high = s_r.sync2[fps_pkg::IN_VCO]
                  ? (flyback_control_level != 8'h00
                     && {1'b0, s_r.osc_cnt} >= vco_per)
                  : (s_r.osc_cnt >= 16'(fps_pkg::MIN_PER_CYC));
  assign valley_ready = osc_high && !demag
                      && s_r.sync2[fps_pkg::IN_VALLEY];
  assign status = {21'h0, s_r.fb_state, 1'b0, s_r.started,
                   s_r.sync2[fps_pkg::IN_DEMAG_OPN], s_r.burst,
                   s_r.restart, s_r.tout_fault, s_r.fb_gate, s_r.pfc_gate};

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pins;
    s_nxt.sync2 = s_r.sync1;

    // Write channel
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = fps_pkg::RESP_OKAY;
      unique case (reg_sel(s_r.awaddr))
        2'h0: begin
          if (s_r.wstrb[0]) begin
            s_nxt.ctrl = s_r.wdata[1:0];
          end
        end
        2'h1: begin
          s_nxt.bresp = fps_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = fps_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;

    // Read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid  = 1'b1;
      s_nxt.arready = 1'b0;
      s_nxt.rresp   = fps_pkg::RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        2'h0: s_nxt.rdata = {30'h0, s_r.ctrl};
        2'h1: s_nxt.rdata = status;
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = fps_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Correction stage
    s_nxt.burst = s_r.sync2[fps_pkg::IN_VCO];
    if (!s_r.burst) begin
      s_nxt.burst_hold = s_nxt.burst;
    end else if (s_r.burst_hold && s_r.sync2[fps_pkg::IN_BURST_LO]) begin
      s_nxt.burst_hold = 1'b0;
      s_nxt.pfc_ss     = 1'b1;
    end else if (s_r.sync2[fps_pkg::IN_BURST_HI]) begin
      s_nxt.burst_hold = 1'b1;
    end
    if (!s_r.burst) begin
      s_nxt.burst_hold = s_nxt.burst;
    end
    s_nxt.pfc_gate = s_r.sync2[fps_pkg::IN_PFC_REQ] && loop_ok
                  && !ovp
                  && !s_r.burst_hold && s_r.ctrl[fps_pkg::CTRL_PFC_EN];
    if (s_r.pfc_gate) begin
      s_nxt.pfc_ss = 1'b0;
    end
    s_nxt.clamp = !loop_ok;

    // Flyback support outputs
    s_nxt.quarter    = s_r.sync2[fps_pkg::IN_VCO];
    s_nxt.bias_en    = !s_r.sync2[fps_pkg::IN_CTRL_BIAS];
    s_nxt.tout_fault = s_r.sync2[fps_pkg::IN_CTRL_TOUT];
    if (s_r.osc_cnt != 16'hffff) begin
      s_nxt.osc_cnt = s_r.osc_cnt + 16'h1;
    end

    // Flyback sequencer
    unique case (s_r.fb_state)
      fps_pkg::FB_IDLE: begin
        s_nxt.fb_gate = 1'b0;
        s_nxt.restart = 1'b0;
        if (s_r.sync2[fps_pkg::IN_VCC_START] && !fb_fault
            && s_r.sync2[fps_pkg::IN_FB_START]
            && s_r.sync2[fps_pkg::IN_SS_DONE]) begin
          s_nxt.fb_state = fps_pkg::FB_ON;
          s_nxt.fb_gate  = 1'b1;
          s_nxt.started  = 1'b1;
          s_nxt.on_cnt   = 13'h0;
          s_nxt.osc_cnt  = 16'h0;
        end
      end
      fps_pkg::FB_ON: begin
        s_nxt.on_cnt = s_r.on_cnt + 13'h1;
        if (s_r.on_cnt == 13'(MAX_ON_CYC - 1)) begin
          s_nxt.fb_state    = fps_pkg::FB_RESTART;
          s_nxt.fb_gate     = 1'b0;
          s_nxt.restart     = 1'b1;
          s_nxt.started     = 1'b0;
          s_nxt.restart_cnt = 12'h0;
        end else if (fb_fault
                     || s_r.sync2[fps_pkg::IN_PEAK]) begin
          s_nxt.fb_state  = fps_pkg::FB_SEC;
          s_nxt.fb_gate   = 1'b0;
          s_nxt.blank_cnt = 9'(fps_pkg::BLANK_CYC);
        end
      end
      fps_pkg::FB_SEC: begin
        if (s_r.blank_cnt != 9'h0) begin
          s_nxt.blank_cnt = s_r.blank_cnt - 9'h1;
        end else if (!demag) begin
          s_nxt.fb_state = fps_pkg::FB_WAIT;
        end
      end
      fps_pkg::FB_WAIT: begin
        if (valley_ready && !fb_fault) begin
          s_nxt.fb_state = fps_pkg::FB_ON;
          s_nxt.fb_gate  = 1'b1;
          s_nxt.on_cnt   = 13'h0;
          s_nxt.osc_cnt  = 16'h0;
        end
      end
      fps_pkg::FB_RESTART: begin
        s_nxt.fb_gate     = 1'b0;
        s_nxt.restart_cnt = s_r.restart_cnt + 12'h1;
        if (s_r.restart_cnt == 12'(fps_pkg::RESTART_CYC - 1)) begin
          s_nxt.fb_state = fps_pkg::FB_IDLE;
        end
      end
      default: begin
        s_nxt.fb_state = fps_pkg::FB_IDLE;
        s_nxt.fb_gate  = 1'b0;
      end
    endcase
    s_nxt.ss_en = s_r.sync2[fps_pkg::IN_VCC_START]
               && !s_nxt.started;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r          <= '0;
      s_r.fb_state <= fps_pkg::FB_IDLE;
      s_r.ctrl     <= fps_pkg::CTRL_RESET;
      s_r.awready  <= 1'b1;
      s_r.wready   <= 1'b1;
      s_r.arready  <= 1'b1;
      s_r.clamp    <= 1'b1;
      s_r.bias_en  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready                = s_r.awready;
  assign s_axi_wready                 = s_r.wready;
  assign s_axi_bvalid                 = s_r.bvalid;
  assign s_axi_bresp                  = s_r.bresp;
  assign s_axi_arready                = s_r.arready;
  assign s_axi_rvalid                 = s_r.rvalid;
  assign s_axi_rdata                  = s_r.rdata;
  assign s_axi_rresp                  = s_r.rresp;
  assign correction_stage_gate_output = s_r.pfc_gate;
  assign compensation_clamp_request   = s_r.clamp;
  assign correction_softstart_request = s_r.pfc_ss;
  assign correction_burst_mode        = s_r.burst;
  assign flyback_gate_output          = s_r.fb_gate;
  assign peak_limit_quarter           = s_r.quarter;
  assign control_bias_enable          = s_r.bias_en;
  assign flyback_softstart_current    = s_r.ss_en;
  assign open_loop_fault              = s_r.tout_fault;
  assign safe_restart                 = s_r.restart;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence stroke_armed;
    s_r.fb_state == fps_pkg::FB_WAIT && valley_ready && !fb_fault;
  endsequence

  sequence stroke_launch;
    s_r.fb_state == fps_pkg::FB_ON && s_r.fb_gate;
  endsequence

  pfc_ovp_block_a: assert property (
    ovp |=> !s_r.pfc_gate
  ) else $error("correction gate on during overvoltage");

  pfc_resume_a: assert property (
    (s_r.sync2[fps_pkg::IN_PFC_REQ] && loop_ok && !ovp && !s_r.burst_hold
     && s_r.ctrl[fps_pkg::CTRL_PFC_EN]) |=> s_r.pfc_gate
  ) else $error("correction gate not resumed");

  clamp_open_loop_a: assert property (
    !loop_ok |=> s_r.clamp && !s_r.pfc_gate
  ) else $error("clamp missing below open-loop level");

  valley_start_a: assert property (
    $rose(s_r.fb_gate) && $past(s_r.fb_state) != fps_pkg::FB_IDLE
      |-> $past(valley_ready)
  ) else $error("stroke began without valley");

  armed_launch_a: assert property (
    stroke_armed |=> stroke_launch ##1 !$rose(s_r.fb_gate)
  ) else $error("stroke launch or single turn-on broken");

  blank_hold_a: assert property (
    (s_r.fb_state == fps_pkg::FB_SEC && s_r.blank_cnt != 9'h0)
      |=> s_r.fb_state == fps_pkg::FB_SEC
  ) else $error("demagnetization not blanked");

  max_on_a: assert property (
    (s_r.fb_state == fps_pkg::FB_ON && s_r.on_cnt == 13'(MAX_ON_CYC - 1))
      |=> s_r.fb_state == fps_pkg::FB_RESTART && !s_r.fb_gate
          && s_r.restart
  ) else $error("maximum on-time not enforced");

  demag_open_a: assert property (
    s_r.sync2[fps_pkg::IN_DEMAG_OPN] && s_r.fb_state != fps_pkg::FB_IDLE
      |=> ##1 !s_r.fb_gate
  ) else $error("flyback kept running with open demag input");

  timeout_flag_a: assert property (
    s_r.sync2[fps_pkg::IN_CTRL_TOUT] |=> s_r.tout_fault
  ) else $error("timeout fault not flagged");

  softstart_off_a: assert property (
    s_r.started |-> !s_r.ss_en
  ) else $error("soft-start current on after start");

  quarter_peak_a: assert property (
    s_r.sync2[fps_pkg::IN_VCO] |=> s_r.quarter && s_r.burst
  ) else $error("low-power limits not applied");

endmodule
`default_nettype wire

// ===== dv/fps_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fps_partner (
  input  wire logic        aclk,
  input  wire logic        gate,
  input  wire logic        peak_en,
  input  wire logic [15:0] dlen,
  output logic             peak,
  output logic             demag,
  output logic             valley
);
  int on_cnt = 0;
  int off_cnt = 0;
  initial begin
    peak = 1'b0;
    demag = 1'b0;
    valley = 1'b0;
  end
  // Peak trips 20 cycles into conduction; secondary stroke lasts dlen
  // cycles after turn-off; valleys then ring every 8 cycles
  always @(posedge aclk) begin
    on_cnt <= gate ? on_cnt + 1 : 0;
    off_cnt <= gate ? 0 : off_cnt + 1;
    peak <= gate && peak_en && on_cnt >= 20;
    demag <= !gate && off_cnt < int'(dlen);
    valley <= !gate && off_cnt >= int'(dlen) && (off_cnt % 8) == 0;
  end
endmodule
`default_nettype wire

// ===== dv/flyback_pfc_switch_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flyback_pfc_switch_sequencer_tb;
  localparam int MAXON = 40;
  logic                        aclk = 1'b0;
  logic                        aresetn = 1'b0;
  logic [fps_pkg::ADDR_W-1:0]  s_axi_awaddr = '0;
  logic [fps_pkg::ADDR_W-1:0]  s_axi_araddr = '0;
  logic [31:0]                 s_axi_wdata = 32'h0;
  logic                        s_axi_awvalid = 1'b0;
  logic                        s_axi_wvalid = 1'b0;
  logic                        s_axi_bready = 1'b0;
  logic                        s_axi_arvalid = 1'b0;
  logic                        s_axi_rready = 1'b0;
  logic                        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                        s_axi_arready, s_axi_rvalid;
  logic [1:0]                  s_axi_bresp, s_axi_rresp;
  logic [31:0]                 s_axi_rdata, seed, d;
  logic [15:0]                 cmp = 16'h0;
  logic [15:0]                 dlen = 16'd600;
  logic [7:0]                  lvl = 8'h80;
  logic                        peak, demag, valley, peak_en = 1'b1;
  logic                        pfc_g, clamp, pss, burst, fb_g;
  logic                        quarter, bias, fss, olf, sr;
  logic                        chk_v = 1'b0, g_d = 1'b0;
  logic [5:0]                  vh = 6'h0;
  logic [1:0]                  r;
  int                          err_count = 0, compares = 0;
  int                          rises = 0, per = 0, ot = 0, r0, k, i;
  int                          minp = fps_pkg::MIN_PER_CYC;
  int                          k_list[3] = '{fps_pkg::IN_CTRL_TOUT,
    fps_pkg::IN_CTRL_GND, fps_pkg::IN_DEMAG_OPN};

  always #2 aclk = ~aclk;

  fps_sequencer #(.MAX_ON_CYC(MAXON)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .bus_overvoltage_cmp(cmp[fps_pkg::IN_OVP]),
    .open_loop_ok_cmp(cmp[fps_pkg::IN_OLOOP_OK]),
    .burst_low_cmp(cmp[fps_pkg::IN_BURST_LO]),
    .burst_high_cmp(cmp[fps_pkg::IN_BURST_HI]),
    .flyback_start_level_cmp(cmp[fps_pkg::IN_FB_START]),
    .supply_start_cmp(cmp[fps_pkg::IN_VCC_START]),
    .softstart_done_cmp(cmp[fps_pkg::IN_SS_DONE]),
    .flyback_peak_cmp(peak), .flyback_demag_input(demag),
    .control_bias_cmp(cmp[fps_pkg::IN_CTRL_BIAS]),
    .control_timeout_cmp(cmp[fps_pkg::IN_CTRL_TOUT]),
    .control_ground_cmp(cmp[fps_pkg::IN_CTRL_GND]),
    .low_power_frequency_mode_cmp(cmp[fps_pkg::IN_VCO]),
    .demag_open_cmp(cmp[fps_pkg::IN_DEMAG_OPN]),
    .high_voltage_valley_input(valley),
    .correction_stage_request(cmp[fps_pkg::IN_PFC_REQ]),
    .flyback_control_level(lvl), .correction_stage_gate_output(pfc_g),
    .compensation_clamp_request(clamp), .correction_softstart_request(pss),
    .correction_burst_mode(burst), .flyback_gate_output(fb_g),
    .peak_limit_quarter(quarter), .control_bias_enable(bias),
    .flyback_softstart_current(fss), .open_loop_fault(olf),
    .safe_restart(sr));

  fps_partner far (.aclk, .gate(fb_g), .peak_en, .dlen, .peak, .demag,
    .valley);

  task automatic print_verdict;
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input string what);
    $display("MISMATCH %s exp done seen timeout", what);
    err_count++;
    print_verdict();
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wait_rise(input int lim);
    int n;
    r0 = rises;
    for (n = 0; n < lim && rises == r0; n++) @(posedge aclk);
    if (rises == r0) tmo("gate turn-on");
  endtask

  // Handshakes are judged from levels held just before each rising edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (tb) break;
    end
    if (n == 50) tmo("axi write");
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic ta, tr;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      if (tr) break;
    end
    if (n == 50) tmo("axi read");
  endtask

  // Reference model of stroke timing, checked at turn-on and turn-off while chk_v is set (max on-time while peak_en is low)
  always @(negedge aclk) begin
    vh = {vh[4:0], valley};
    per++;
    ot = fb_g ? (g_d ? ot + 1 : 1) : ot;
    if (fb_g && !g_d) begin
      if (chk_v) check("period", per >= minp && per <= minp + 16, 1);
      if (chk_v) check("valley", vh != 0 && demag == 0, 1);
      per = 0;
      rises++;
    end
    if (!fb_g && g_d && chk_v) check("on time", ot >= 22 && ot <= 27, 1);
    if (!fb_g && g_d && !peak_en) check("max on", ot >= MAXON - 1 && ot <= MAXON + 1, 1);
    g_d = fb_g;
  end

  initial begin
    seed = 32'h833a4101;
    cyc(12);
    aresetn <= 1'b1;
    cyc(1);
    check("clamp", clamp, 1);
    check("bias", bias, 1);
    axi_rd(fps_pkg::CTRL_OFS);
    check("ctrl", d, {30'h0, fps_pkg::CTRL_RESET});
    axi_rd(4'h8);
    check("rresp", r, fps_pkg::RESP_SLVERR);
    axi_wr(4'hc, 32'h0);
    check("bresp", r, fps_pkg::RESP_SLVERR);
    axi_wr(fps_pkg::CTRL_OFS, 32'h1);
    cmp <= 16'h1 << fps_pkg::IN_OLOOP_OK | 16'h1 << fps_pkg::IN_PFC_REQ;
    cyc(6);
    check("pfc off", pfc_g, 0);
    axi_wr(fps_pkg::CTRL_OFS, 32'h3);
    for (i = 0; i < 40; i++) begin
      d = rnd();
      cmp[fps_pkg::IN_OVP] <= d[0];
      cmp[fps_pkg::IN_OLOOP_OK] <= d[1] | d[2];
      cmp[fps_pkg::IN_PFC_REQ] <= d[3];
      cyc(6);
      check("pfc gate", pfc_g, d[3] & (d[1] | d[2]) & !d[0]);
      check("clamp", clamp, !(d[1] | d[2]));
    end
    cmp[fps_pkg::IN_VCC_START] <= 1'b1;
    cmp[fps_pkg::IN_FB_START] <= 1'b1;
    cyc(6);
    check("ss current", fss, 1);
    check("fb wait", fb_g, 0);
    cmp[fps_pkg::IN_SS_DONE] <= 1'b1;
    wait_rise(10);
    cyc(2);
    check("ss current", fss, 0);
    chk_v = 1'b1;
    cyc(9000);
    chk_v = 1'b0;
    dlen <= 16'd3000;
    minp = 3024;
    cyc(4000);
    chk_v = 1'b1;
    cyc(7000);
    chk_v = 1'b0;
    dlen <= 16'd600;
    lvl <= 8'hf0 | 8'(rnd() & 32'hf);
    cmp <= cmp | 16'h1 << fps_pkg::IN_VCO | 16'h1 << fps_pkg::IN_PFC_REQ
      | 16'h1 << fps_pkg::IN_OLOOP_OK;
    cyc(6);
    check("quarter", quarter, 1);
    check("burst", burst, 1);
    check("burst hold", pfc_g, 0);
    minp = fps_pkg::MIN_PER_CYC + (255 - int'(lvl)) * fps_pkg::VCO_STEP_CYC;
    cmp[fps_pkg::IN_BURST_LO] <= 1'b1;
    cyc(4);
    check("burst ss", pss, 1);
    cyc(2);
    check("burst go", pfc_g, 1);
    cyc(6000);
    chk_v = 1'b1;
    cyc(11000);
    chk_v = 1'b0;
    cmp[fps_pkg::IN_VCO] <= 1'b0;
    cmp[fps_pkg::IN_CTRL_BIAS] <= 1'b1;
    cyc(6);
    check("bias", bias, 0);
    foreach (k_list[j]) begin
      k = k_list[j];
      cmp[k] <= 1'b1;
      cyc(40);
      check("fault stop", fb_g, 0);
      if (k == fps_pkg::IN_CTRL_TOUT) check("timeout", olf, 1);
      r0 = rises;
      cyc(5000);
      check("no turn-on", rises, r0);
      cmp[k] <= 1'b0;
      wait_rise(9000);
    end
    peak_en <= 1'b0;
    for (i = 0; i < 3000 && sr !== 1'b1; i++) @(posedge aclk);
    if (sr !== 1'b1) tmo("safe restart");
    check("restart gate", fb_g, 0);
    axi_rd(fps_pkg::STAT_OFS);
    check("stat state", d[10:8], 3'h6);
    check("stat restart", d[3], 1);
    peak_en <= 1'b1;
    wait_rise(fps_pkg::RESTART_CYC + 100);
    print_verdict();
  end
endmodule
`default_nettype wire
